// >>> banked_data_memory_status.sv
// banked data memory decode, core registers and arithmetic/reset status
`timescale 1ns/1ps
`default_nettype none
module banked_data_memory_status (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire dm_pkg::access_req_t req,
  input wire dm_pkg::status_event_t ev,
  input wire logic [7:0] periph_rdata,
  output logic [7:0] rd_data_q,
  output logic rd_valid_q,
  output dm_pkg::periph_bus_t periph_q,
  output logic [7:0] status_q,
  output logic [4:0] bank_select_q,
  output logic [7:0] accum_q,
  output logic [15:0] pointer0_q,
  output logic [15:0] pointer1_q
);
  dm_pkg::core_state_t s;
  dm_pkg::core_state_t n;

  logic [12:0] tgt;
  logic [7:0] loc;
  logic [6:0] off;
  logic ok;
  logic [7:0] res;
  logic [8:0] sum;
  logic [4:0] nib;
  logic fz;
  logic fdc;
  logic fc;
  logic z_upd;
  logic dc_upd;
  logic c_upd;
  logic flag_op;
  logic executes;
  logic st_rd;
  logic st_wr;
  logic [7:0] st_q;

  // ------------------------------------------------------------
  // address forming
  // ------------------------------------------------------------

  // offsets 0/1 go through a pointer; a pointer landing on the
  // indirect slots again reads zero to avoid endless indirection
  function automatic logic [12:0] resolve(
    input logic [6:0] o,
    input logic [4:0] bk,
    input logic [15:0] p0,
    input logic [15:0] p1
  );
    logic [15:0] p;
    logic [15:0] lin;
    p = o[0] ? p1 : p0;
    lin = p - dm_pkg::LINEAR_BASE;
    if (o > dm_pkg::OFF_INDIRECT1) begin
      resolve = {1'b1, bk, o};
    end else if (p[15:12] == 4'h0 &&
                 p[6:0] > dm_pkg::OFF_INDIRECT1) begin
      resolve = {1'b1, p[11:0]};
    end else if (p >= dm_pkg::LINEAR_BASE &&
                 lin < dm_pkg::LINEAR_GRAM_BYTES) begin
      // linear window ignores bank_select
      resolve = {1'b1, dm_pkg::GRAM_BANK,
                 dm_pkg::GRAM_FIRST + lin[6:0]};
    end else begin
      resolve = 13'h0000;
    end
  endfunction : resolve

  // region and store index of a 12-bit address
  function automatic logic [7:0] locate(input logic [11:0] a);
    logic [6:0] o;
    logic [6:0] g;
    o = a[6:0];
    g = o - dm_pkg::GRAM_FIRST;
    if (o <= dm_pkg::OFF_INT_CTRL) begin
      locate = {dm_pkg::SRC_CORE, 6'h00};
    end else if (o <= dm_pkg::PERIPH_LAST) begin
      locate = {dm_pkg::SRC_PERIPH, 6'h00};
    end else if (o >= dm_pkg::COMMON_FIRST) begin
      locate = {dm_pkg::SRC_STORE,
                dm_pkg::COMMON_IDX_BASE | {2'b00, o[3:0]}};
    end else if (a[11:7] == dm_pkg::GRAM_BANK &&
                 o <= dm_pkg::GRAM_BANK0_LAST) begin
      locate = {dm_pkg::SRC_STORE, g[5:0]};
    end else begin
      locate = {dm_pkg::SRC_ZERO, 6'h00};
    end
  endfunction : locate

  // ------------------------------------------------------------
  // arithmetic and flags
  // ------------------------------------------------------------
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    res = req.opa;
    fc = s.status[dm_pkg::ST_C];
    z_upd = 1'b0;
    dc_upd = 1'b0;
    c_upd = 1'b0;
    case (req.op)
      dm_pkg::ALU_PASS: begin
        res = req.opa;
      end
      dm_pkg::ALU_LOGIC: begin
        z_upd = 1'b1;
      end
      dm_pkg::ALU_ADD: begin
        sum = {1'b0, req.opa} + {1'b0, req.opb};
        nib = {1'b0, req.opa[3:0]} + {1'b0, req.opb[3:0]};
        res = sum[7:0];
        fc = sum[8];
        z_upd = 1'b1;
        dc_upd = 1'b1;
        c_upd = 1'b1;
      end
      dm_pkg::ALU_SUB: begin
        // two's complement add: carry out means no borrow
        sum = {1'b0, req.opa} + {1'b0, ~req.opb} + 9'h001;
        nib = {1'b0, req.opa[3:0]} + {1'b0, ~req.opb[3:0]} + 5'h01;
        res = sum[7:0];
        fc = sum[8];
        z_upd = 1'b1;
        dc_upd = 1'b1;
        c_upd = 1'b1;
      end
      dm_pkg::ALU_ROT_LEFT: begin
        res = {req.opa[6:0], s.status[dm_pkg::ST_C]};
        fc = req.opa[7];
        c_upd = 1'b1;
      end
      dm_pkg::ALU_ROT_RIGHT: begin
        res = {s.status[dm_pkg::ST_C], req.opa[7:1]};
        fc = req.opa[0];
        c_upd = 1'b1;
      end
      default: begin
        res = req.opa;
      end
    endcase
    fdc = nib[4];
    fz = (res == 8'h00);
  end

  assign executes = req.wr_file || req.wr_accum;
  assign flag_op = executes && (z_upd || dc_upd || c_upd);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    tgt = resolve(req.offset, s.bank, s.ptr0, s.ptr1);
    ok = tgt[12];
    off = tgt[6:0];
    loc = ok ? locate(tgt[11:0]) : {dm_pkg::SRC_ZERO, 6'h00};
    st_rd = req.rd && loc[7:6] == dm_pkg::SRC_STORE;
    st_wr = req.wr_file && loc[7:6] == dm_pkg::SRC_STORE;
    n = s;
    n.periph.wr = 1'b0;
    n.periph.rd = 1'b0;
    n.rd_valid = 1'b0;
    // read: stage one captures source, stage two returns data
    n.pend = req.rd;
    n.src = dm_pkg::read_src_t'(loc[7:6]);
    case (off)
      dm_pkg::OFF_PC_LOW: n.core_q = s.program_counter_low;
      dm_pkg::OFF_STATUS: n.core_q = {3'b000, s.status};
      dm_pkg::OFF_PTR0_LOW: n.core_q = s.ptr0[7:0];
      dm_pkg::OFF_PTR0_HIGH: n.core_q = s.ptr0[15:8];
      dm_pkg::OFF_PTR1_LOW: n.core_q = s.ptr1[7:0];
      dm_pkg::OFF_PTR1_HIGH: n.core_q = s.ptr1[15:8];
      dm_pkg::OFF_BANK_SELECT: n.core_q = {3'b000, s.bank};
      dm_pkg::OFF_ACCUM: n.core_q = s.accum;
      dm_pkg::OFF_PC_LATCH: n.core_q = s.program_counter_upper_latch;
      dm_pkg::OFF_INT_CTRL: n.core_q = s.interrupt_control;
      default: n.core_q = 8'h00;
    endcase
    if (loc[7:6] == dm_pkg::SRC_PERIPH) begin
      n.periph.addr = tgt[11:0];
      n.periph.rd = req.rd;
      n.periph.wr = req.wr_file;
      n.periph.wdata = res;
    end
    if (s.pend) begin
      n.rd_valid = 1'b1;
      case (s.src)
        dm_pkg::SRC_CORE: n.rd_data = s.core_q;
        dm_pkg::SRC_STORE: n.rd_data = st_q;
        dm_pkg::SRC_PERIPH: n.rd_data = periph_rdata;
        default: n.rd_data = 8'h00;
      endcase
    end
    // file write into the core registers
    if (req.wr_file && loc[7:6] == dm_pkg::SRC_CORE) begin
      case (off)
        dm_pkg::OFF_PC_LOW: n.program_counter_low = res;
        dm_pkg::OFF_STATUS: begin
          if (!flag_op) begin
            n.status[2:0] = res[2:0];
          end
        end
        dm_pkg::OFF_PTR0_LOW: n.ptr0[7:0] = res;
        dm_pkg::OFF_PTR0_HIGH: n.ptr0[15:8] = res;
        dm_pkg::OFF_PTR1_LOW: n.ptr1[7:0] = res;
        dm_pkg::OFF_PTR1_HIGH: n.ptr1[15:8] = res;
        dm_pkg::OFF_BANK_SELECT: n.bank = res[4:0];
        dm_pkg::OFF_ACCUM: n.accum = res;
        dm_pkg::OFF_PC_LATCH: n.program_counter_upper_latch = res;
        dm_pkg::OFF_INT_CTRL: n.interrupt_control = res;
        default: n.program_counter_low = s.program_counter_low;
      endcase
    end
    if (req.wr_accum) begin
      n.accum = res;
    end
    // flag results override any destination write
    if (executes && z_upd) begin
      n.status[dm_pkg::ST_Z] = fz;
    end
    if (executes && dc_upd) begin
      n.status[dm_pkg::ST_DC] = fdc;
    end
    if (executes && c_upd) begin
      n.status[dm_pkg::ST_C] = fc;
    end
    // hardware events; a timeout wins over a kick in the same cycle
    if (ev.watchdog_kick) begin
      n.status[dm_pkg::ST_TO] = 1'b1;
      n.status[dm_pkg::ST_PD] = 1'b1;
    end
    if (ev.sleep_exec) begin
      n.status[dm_pkg::ST_TO] = 1'b1;
      n.status[dm_pkg::ST_PD] = 1'b0;
    end
    if (ev.wdt_timeout) begin
      n.status[dm_pkg::ST_TO] = 1'b0;
    end
    if (ev.warm_reset) begin
      n.status[dm_pkg::ST_TO] = ev.warm_expiry_n;
      n.status[dm_pkg::ST_PD] = ev.warm_sleep_n;
    end
  end

  // rst is the power-on / brown-out reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= dm_pkg::STATE_RESET;
    end else if (clk_en) begin
      s <= n;
    end
  end

  ram_store u_store (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .rd_en(st_rd),
    .wr_en(st_wr),
    .idx(loc[5:0]),
    .wdata(res),
    .rdata(st_q)
  );

  assign rd_data_q = s.rd_data;
  assign rd_valid_q = s.rd_valid;
  assign periph_q = s.periph;
  assign status_q = {3'b000, s.status};
  assign bank_select_q = s.bank;
  assign accum_q = s.accum;
  assign pointer0_q = s.ptr0;
  assign pointer1_q = s.ptr1;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [8:0] add_ref;
  logic add_c_ref;
  logic sub_nb_ref;
  logic no_ev;

  assign add_ref = {1'b0, req.opa} + {1'b0, req.opb};
  assign add_c_ref = add_ref[8];
  assign sub_nb_ref = (req.opa >= req.opb);
  assign no_ev = !(ev.wdt_timeout || ev.watchdog_kick ||
                   ev.sleep_exec || ev.warm_reset);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  bank_follow_a: assert property (
    clk_en && req.wr_file && req.offset == dm_pkg::OFF_BANK_SELECT &&
    req.op == dm_pkg::ALU_PASS |=> bank_select_q == $past(req.opa[4:0]))
    else $error("bank select did not follow write");

  status_top_a: assert property (
    (clk_en && req.rd && req.offset == dm_pkg::OFF_STATUS) ##1 clk_en
    |=> rd_valid_q && rd_data_q[7:5] == 3'b000 &&
    rd_data_q == $past(status_q, 2))
    else $error("status upper bits not zero");

  unimpl_zero_a: assert property (
    (clk_en && req.rd && req.offset >= 7'h50 && req.offset <= 7'h6f)
    ##1 clk_en |=> rd_valid_q && rd_data_q == 8'h00)
    else $error("unimplemented read not zero");

  flag_protect_a: assert property (
    clk_en && req.wr_file && req.offset == dm_pkg::OFF_STATUS && no_ev
    |=> status_q[4:3] == $past(status_q[4:3]))
    else $error("protected status bits written");

  add_carry_a: assert property (
    clk_en && req.wr_file && req.offset == dm_pkg::OFF_STATUS &&
    req.op == dm_pkg::ALU_ADD |=> status_q[0] == $past(add_c_ref))
    else $error("carry not taken from add");

  sub_borrow_a: assert property (
    clk_en && req.wr_accum && req.op == dm_pkg::ALU_SUB
    |=> status_q[0] == $past(sub_nb_ref))
    else $error("subtract carry is not inverted borrow");

  rotate_carry_a: assert property (
    clk_en && req.wr_accum && req.op == dm_pkg::ALU_ROT_LEFT
    |=> status_q[0] == $past(req.opa[7]))
    else $error("rotate carry wrong");

  sleep_flags_a: assert property (
    clk_en && ev.sleep_exec && !ev.wdt_timeout && !ev.warm_reset
    |=> status_q[4:3] == 2'b10)
    else $error("sleep flags wrong");

  kick_flags_a: assert property (
    clk_en && ev.watchdog_kick && !ev.sleep_exec && !ev.wdt_timeout &&
    !ev.warm_reset |=> status_q[4:3] == 2'b11)
    else $error("kick flags wrong");

  timeout_flag_a: assert property (
    clk_en && ev.wdt_timeout && !ev.warm_reset |=> !status_q[4])
    else $error("timeout did not clear expiry flag");

  por_value_a: assert property (disable iff (1'b0)
    rst |=> status_q == 8'h18 && bank_select_q == 5'h00)
    else $error("power-on status wrong");

  common_read_c: cover property (
    clk_en && req.rd && req.offset >= dm_pkg::COMMON_FIRST);
  linear_ptr_c: cover property (
    clk_en && req.rd && req.offset == 7'h00 &&
    pointer0_q[15:12] == 4'h2);
  sleep_c: cover property (clk_en && ev.sleep_exec);
  status_add_c: cover property (clk_en && req.wr_file &&
    req.offset == dm_pkg::OFF_STATUS && req.op == dm_pkg::ALU_ADD);
endmodule : banked_data_memory_status
`default_nettype wire

// >>> dm_pkg.sv
// constants and types of the banked data memory and its status flags
package dm_pkg;
  localparam int BANK_W = 5;
  localparam int OFF_W = 7;
  localparam int ADDR_W = BANK_W + OFF_W;
  localparam int NUM_BANKS = 32;
  localparam int BANK_BYTES = 128;
  localparam logic [6:0] OFF_INDIRECT1 = 7'h01;
  localparam logic [6:0] OFF_PC_LOW = 7'h02;
  localparam logic [6:0] OFF_STATUS = 7'h03;
  localparam logic [6:0] OFF_PTR0_LOW = 7'h04;
  localparam logic [6:0] OFF_PTR0_HIGH = 7'h05;
  localparam logic [6:0] OFF_PTR1_LOW = 7'h06;
  localparam logic [6:0] OFF_PTR1_HIGH = 7'h07;
  localparam logic [6:0] OFF_BANK_SELECT = 7'h08;
  localparam logic [6:0] OFF_ACCUM = 7'h09;
  localparam logic [6:0] OFF_PC_LATCH = 7'h0a;
  localparam logic [6:0] OFF_INT_CTRL = 7'h0b;
  localparam logic [6:0] PERIPH_LAST = 7'h1f;
  localparam logic [6:0] GRAM_FIRST = 7'h20;
  localparam logic [6:0] GRAM_BANK0_LAST = 7'h4f;
  localparam logic [6:0] COMMON_FIRST = 7'h70;
  localparam logic [4:0] GRAM_BANK = 5'h00;
  localparam logic [15:0] LINEAR_BASE = 16'h2000;
  localparam logic [15:0] LINEAR_GRAM_BYTES = 16'h0030;
  localparam logic [5:0] COMMON_IDX_BASE = 6'h30;
  localparam int STORE_DEPTH = 64;
  localparam int STORE_IDX_W = 6;
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  localparam int ST_Z = 2;
  localparam int ST_DC = 1;
  localparam int ST_C = 0;
  localparam logic [4:0] STATUS_POR = 5'h18;

  typedef enum logic [2:0] {
    ALU_PASS = 3'b000,
    ALU_LOGIC = 3'b001,
    ALU_ADD = 3'b010,
    ALU_SUB = 3'b011,
    ALU_ROT_LEFT = 3'b100,
    ALU_ROT_RIGHT = 3'b101
  } alu_op_t;

  typedef enum logic [1:0] {
    SRC_ZERO = 2'b00,
    SRC_CORE = 2'b01,
    SRC_STORE = 2'b10,
    SRC_PERIPH = 2'b11
  } read_src_t;

  typedef struct packed {
    logic rd;
    logic wr_file;
    logic wr_accum;
    logic [6:0] offset;
    alu_op_t op;
    logic [7:0] opa;
    logic [7:0] opb;
  } access_req_t;

  typedef struct packed {
    logic wdt_timeout;
    logic watchdog_kick;
    logic sleep_exec;
    logic warm_reset;
    logic warm_expiry_n;
    logic warm_sleep_n;
  } status_event_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } periph_bus_t;

  typedef struct packed {
    logic [4:0] bank;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [7:0] accum;
    logic [7:0] program_counter_low;
    logic [7:0] program_counter_upper_latch;
    logic [7:0] interrupt_control;
    logic [4:0] status;
    read_src_t src;
    logic [7:0] core_q;
    logic pend;
    logic rd_valid;
    logic [7:0] rd_data;
    periph_bus_t periph;
  } core_state_t;

  localparam core_state_t STATE_RESET = '{
    bank: 5'h00, ptr0: 16'h0000, ptr1: 16'h0000, accum: 8'h00,
    program_counter_low: 8'h00, program_counter_upper_latch: 8'h00, interrupt_control: 8'h00, status: STATUS_POR,
    src: SRC_ZERO, core_q: 8'h00, pend: 1'b0, rd_valid: 1'b0,
    rd_data: 8'h00, periph: '{wr: 1'b0, rd: 1'b0, addr: 12'h000,
    wdata: 8'h00}};
endpackage : dm_pkg

// >>> ram_store.sv
// byte store holding the general RAM and the shared common RAM
`timescale 1ns/1ps
`default_nettype none
module ram_store (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [dm_pkg::STORE_IDX_W-1:0] idx,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem_r [dm_pkg::STORE_DEPTH];
  logic [7:0] rdata_r;

  // contents are not cleared by reset, like real SRAM
  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_en) begin
      mem_r[idx] <= wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (clk_en && rd_en) begin
      rdata_r <= mem_r[idx];
    end
  end

  assign rdata = rdata_r;
endmodule : ram_store
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the banked data memory and its status flags
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk;
  logic rst;
  logic clk_en;
  dm_pkg::access_req_t req;
  dm_pkg::status_event_t ev;
  logic [7:0] periph_rdata;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  dm_pkg::periph_bus_t periph_q;
  logic [7:0] status_q;
  logic [4:0] bank_select_q;
  logic [7:0] accum_q;
  logic [15:0] pointer0_q;
  logic [15:0] pointer1_q;
  int fails;
  int n_checks;
  integer seed;
  logic [4:0] s_exp;
  logic [4:0] bk;
  logic [7:0] acc;
  logic [7:0] gram [48];
  logic [7:0] comm [16];
  dm_pkg::alu_op_t ops [6];

  banked_data_memory_status u_banked_data_memory_status (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .req(req), .ev(ev),
    .periph_rdata(periph_rdata), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .periph_q(periph_q), .status_q(status_q),
    .bank_select_q(bank_select_q), .accum_q(accum_q),
    .pointer0_q(pointer0_q), .pointer1_q(pointer1_q));

  // peripheral side answers with a pattern tied to the address it sees
  assign periph_rdata = periph_q.addr[7:0] ^ 8'h5a;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // expectation helpers
  // ----------------------------------------
  function automatic logic is_per(input logic [6:0] o);
    is_per = (o >= 7'h0c) && (o <= 7'h1f);
  endfunction : is_per

  // returns {result, next status low five bits}
  function automatic logic [12:0] alu(input dm_pkg::alu_op_t op,
      input logic [7:0] a, input logic [7:0] b, input logic [4:0] sin);
    logic [8:0] t;
    logic [4:0] h;
    logic [4:0] s;
    s = sin;
    t = {1'b0, a};
    h = 5'h00;
    case (op)
      dm_pkg::ALU_ADD: begin
        t = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      end
      // borrow shows as a missing carry of a plus not b plus one
      dm_pkg::ALU_SUB: begin
        t = {1'b0, a} + {1'b0, ~b} + 9'h001;
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      end
      dm_pkg::ALU_ROT_LEFT: t = {a, s[0]};
      dm_pkg::ALU_ROT_RIGHT: t = {a[0], s[0], a[7:1]};
      default: ;
    endcase
    if (op == dm_pkg::ALU_ADD || op == dm_pkg::ALU_SUB) s[1:0] = {h[4], t[8]};
    if (op == dm_pkg::ALU_ADD || op == dm_pkg::ALU_SUB ||
        op == dm_pkg::ALU_LOGIC) s[2] = (t[7:0] == 8'h00);
    if (op == dm_pkg::ALU_ROT_LEFT || op == dm_pkg::ALU_ROT_RIGHT) s[0] = t[8];
    alu = {t[7:0], s};
  endfunction : alu

  // ----------------------------------------
  // drivers and comparison
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic issue(input logic r, input logic w, input logic a,
      input logic [6:0] o, input dm_pkg::alu_op_t op, input logic [7:0] x,
      input logic [7:0] y);
    req = '{rd: r, wr_file: w, wr_accum: a, offset: o, op: op, opa: x,
      opb: y};
    @(posedge sys_clk);
    req <= '0;
    #1;
  endtask : issue

  task automatic wr(input logic [6:0] o, input logic [7:0] x);
    issue(1'b0, 1'b1, 1'b0, o, dm_pkg::ALU_PASS, x, 8'h00);
    chk(periph_q.wr, is_per(o));
    if (is_per(o)) begin
      chk(periph_q.addr, {bk, o});
      chk(periph_q.wdata, x);
    end
  endtask : wr

  task automatic rd(input logic [6:0] o, input logic [7:0] exp);
    int i;
    issue(1'b1, 1'b0, 1'b0, o, dm_pkg::ALU_PASS, 8'h00, 8'h00);
    chk(periph_q.rd, is_per(o));
    for (i = 0; i < 4 && rd_valid_q !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (rd_valid_q !== 1'b1) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, rd_valid_q, 1'b1);
      tally_and_finish();
    end
    chk(rd_data_q, exp);
  endtask : rd

  task automatic setp(input logic p1, input logic [15:0] v);
    wr(p1 ? dm_pkg::OFF_PTR1_LOW : dm_pkg::OFF_PTR0_LOW, v[7:0]);
    wr(p1 ? dm_pkg::OFF_PTR1_HIGH : dm_pkg::OFF_PTR0_HIGH, v[15:8]);
    chk(p1 ? pointer1_q : pointer0_q, v);
  endtask : setp

  task automatic alu_op(input dm_pkg::alu_op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic to_st);
    logic [12:0] r;
    r = alu(op, a, b, s_exp);
    issue(1'b0, to_st, ~to_st, dm_pkg::OFF_STATUS, op, a, b);
    s_exp = r[4:0];
    // a flagless write to status lands in the low three bits only
    if (to_st && op == dm_pkg::ALU_PASS) s_exp[2:0] = a[2:0];
    if (!to_st) acc = r[12:5];
    chk(accum_q, acc);
    chk(status_q, {3'b000, s_exp});
  endtask : alu_op

  task automatic evt(input logic [5:0] v, input logic [1:0] ts);
    ev = v;
    @(posedge sys_clk);
    ev <= '0;
    #1;
    s_exp[4:3] = ts;
    chk(status_q, {3'b000, s_exp});
  endtask : evt

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] x;
    logic [31:0] r;
    int b;
    int k;
    seed = 32'hd88e860c;
    rst = 1'b1;
    clk_en = 1'b1;
    req = '0;
    ev = '0;
    fails = 0;
    n_checks = 0;
    bk = 5'h00;
    acc = 8'h00;
    s_exp = 5'h18;
    ops = '{dm_pkg::ALU_PASS, dm_pkg::ALU_LOGIC, dm_pkg::ALU_ADD,
      dm_pkg::ALU_SUB, dm_pkg::ALU_ROT_LEFT, dm_pkg::ALU_ROT_RIGHT};
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk(status_q, 8'h18);
    chk(bank_select_q, 5'h00);
    x = $random(seed);
    wr(dm_pkg::OFF_ACCUM, x);
    acc = x;
    chk(accum_q, x);
    wr(dm_pkg::OFF_PC_LATCH, ~x);
    rd(dm_pkg::OFF_PC_LATCH, ~x);
    for (k = 0; k < 48; k++) begin
      gram[k] = $random(seed);
      wr(dm_pkg::GRAM_FIRST + 7'(k), gram[k]);
    end
    for (k = 0; k < 16; k++) begin
      comm[k] = $random(seed);
      wr(dm_pkg::COMMON_FIRST + 7'(k), comm[k]);
    end
    // every bank: select, stray ram write, common alias, peripherals
    for (b = 0; b < 32; b++) begin
      r = $random(seed);
      wr(dm_pkg::OFF_BANK_SELECT, {r[7:5], 5'(b)});
      bk = 5'(b);
      chk(bank_select_q, bk);
      rd(dm_pkg::OFF_BANK_SELECT, {3'b000, bk});
      k = (b + 17) % 48;
      wr(dm_pkg::GRAM_FIRST + 7'(k), r[15:8]);
      if (b == 0) gram[k] = r[15:8];
      rd(dm_pkg::GRAM_FIRST + 7'(k), (b == 0) ? gram[k] : 8'h00);
      rd(7'h50 + 7'(b), 8'h00);
      rd(dm_pkg::COMMON_FIRST + 7'(b % 16), comm[b % 16]);
      comm[(b + 3) % 16] = r[23:16];
      wr(dm_pkg::COMMON_FIRST + 7'((b + 3) % 16), r[23:16]);
      wr(7'h0c + 7'(b % 20), r[31:24]);
      rd(7'h0c + 7'((b + 7) % 20), {bk[0], 7'h0c + 7'((b + 7) % 20)} ^ 8'h5a);
    end
    // general ram lives in bank 0 only, so select it for the sweep
    wr(dm_pkg::OFF_BANK_SELECT, 8'h00);
    bk = 5'h00;
    for (k = 0; k < 48; k++) rd(dm_pkg::GRAM_FIRST + 7'(k), gram[k]);
    wr(dm_pkg::OFF_BANK_SELECT, 8'h1f);
    bk = 5'h1f;
    // indirect and linear access while a far bank is selected
    setp(1'b0, 16'h0025);
    rd(7'h00, gram[5]);
    setp(1'b0, 16'h0172);
    rd(7'h00, comm[2]);
    k = 29;
    setp(1'b1, 16'h2000 + 16'(k));
    rd(7'h01, gram[k]);
    x = $random(seed);
    wr(7'h01, x);
    gram[k] = x;
    setp(1'b0, 16'h0020 + 16'(k));
    rd(7'h00, x);
    setp(1'b1, 16'h2030);
    rd(7'h01, 8'h00);
    // flag corners, then random operations
    alu_op(dm_pkg::ALU_SUB, 8'h37, 8'h37, 1'b0);
    alu_op(dm_pkg::ALU_SUB, 8'h10, 8'h01, 1'b0);
    alu_op(dm_pkg::ALU_ADD, 8'hff, 8'h01, 1'b0);
    alu_op(dm_pkg::ALU_ADD, 8'h0f, 8'h01, 1'b0);
    alu_op(dm_pkg::ALU_ROT_LEFT, 8'h80, 8'h00, 1'b0);
    alu_op(dm_pkg::ALU_ROT_RIGHT, 8'h01, 8'h00, 1'b0);
    alu_op(dm_pkg::ALU_ADD, 8'h88, 8'h88, 1'b1);
    alu_op(dm_pkg::ALU_PASS, 8'h05, 8'h00, 1'b1);
    for (k = 0; k < 60; k++) begin
      r = $random(seed);
      alu_op(ops[r[7:0] % 6], r[15:8], r[23:16], (r[26:24] == 3'h0));
    end
    // reset flags: events, protected writes, warm reset
    evt(6'b001000, 2'b10);
    evt(6'b100000, 2'b00);
    wr(dm_pkg::OFF_STATUS, 8'hff);
    s_exp[2:0] = 3'b111;
    chk(status_q, 8'h07);
    rd(dm_pkg::OFF_STATUS, 8'h07);
    evt(6'b000101, 2'b01);
    evt(6'b010000, 2'b11);
    wr(dm_pkg::OFF_STATUS, 8'he0);
    chk(status_q, 8'h18);
    // frozen clock enable must drop the instruction
    clk_en = 1'b0;
    issue(1'b0, 1'b0, 1'b1, 7'h00, dm_pkg::ALU_PASS, ~acc, 8'h00);
    clk_en = 1'b1;
    chk(accum_q, acc);
    rst = 1'b1;
    @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk(status_q, 8'h18);
    chk(bank_select_q, 5'h00);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
